// File: logic/filter_gate.sv
`timescale 1ns/1ps
`include "mgmt_filter_defines.svh"

module filter_gate #(
	parameter int NUM_FILTERS = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [NUM_FILTERS-1:0] route_hit,
	input wire logic [NUM_FILTERS-1:0] filter_hit,
	input wire logic [NUM_FILTERS-1:0] copy_mask,
	input wire logic [NUM_FILTERS-1:0] bind_mask,
	input wire logic mgmt_ip_match,
	input wire logic host_ip_match,
	output logic [NUM_FILTERS-1:0] host_copy_ff,
	output logic [NUM_FILTERS-1:0] filter_pass_ff
);

	// ==========================================================
	// Per-filter gating
	genvar i;
	generate
		for (i = 0; i < NUM_FILTERS; i++) begin : g_filter
			wire logic ip_ok;
			wire logic nxt_copy;
			wire logic nxt_pass;
			// The RMCP slot is qualified by the host address match, all others by the
			// controller address match
			if (i == `MHB_BIND_RMCP_BIT) begin : g_rmcp
				assign ip_ok = host_ip_match;
			end else begin : g_mgmt
				assign ip_ok = mgmt_ip_match;
			end
			// A bound filter passes only on an address match
			assign nxt_pass = filter_hit[i] & (~bind_mask[i] | ip_ok);
			// A copied filter also hands its traffic to the host
			assign nxt_copy = route_hit[i] & copy_mask[i];
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					host_copy_ff[i] <= 1'b0;
					filter_pass_ff[i] <= 1'b0;
				end else begin
					host_copy_ff[i] <= nxt_copy;
					filter_pass_ff[i] <= nxt_pass;
				end
			end
		end
	endgenerate

endmodule : filter_gate

// File: logic/mgmt_filter_defines.svh
`ifndef MGMT_FILTER_DEFINES_SVH
`define MGMT_FILTER_DEFINES_SVH

// ==========================================================
// Register location on the paged management interface
`define MHB_PHY_ADDR 5'h01
`define MHB_PAGE 11'h321
`define MHB_COPY_LO_NUM 6'h20
`define MHB_COPY_HI_NUM 6'h21
`define MHB_BIND_LO_NUM 6'h28
`define MHB_BIND_HI_NUM 6'h29

// ==========================================================
// Writable bit masks per 16-bit half, reserved bits are zero
`define MHB_COPY_LO_MASK 16'hF7FF
`define MHB_COPY_HI_MASK 16'h7755
`define MHB_BIND_LO_MASK 16'hD7FF
`define MHB_BIND_HI_MASK 16'hFFFF

// ==========================================================
// Reset values and field positions
`define MHB_COPY_RESET 32'h0000_0000
`define MHB_BIND_RESET 32'h0000_0000
`define MHB_BIND_RMCP_BIT 31
`define MHB_CYCLES_TO_OUT 1

`endif

// File: logic/mgmt_filter_pkg.sv
package mgmt_filter_pkg;

	// Half of a control register as seen on the management interface
	typedef logic [15:0] mdio_word_t;

	// Full control register
	typedef logic [31:0] ctrl_reg_t;

	// Register select after address decode
	typedef enum logic [4:0] {
		SEL_NONE = 5'b00001,
		SEL_COPY_LO = 5'b00010,
		SEL_COPY_HI = 5'b00100,
		SEL_BIND_LO = 5'b01000,
		SEL_BIND_HI = 5'b10000
	} reg_sel_t;

endpackage : mgmt_filter_pkg

// File: logic/mgmt_host_copy_ip_binding.sv
`timescale 1ns/1ps
`include "mgmt_filter_defines.svh"

// Functional notes
// - Copy bits 0-10 and 12-15 send controller-routed TCP/UDP/DHCPv6/EAPoUDP/DNS packets to host.
// - Copy bits 16,18,20,22,24,25,26,28-30 do likewise for further filters.
// - Binding bits 0-10 gate TCP port filters on controller IPv4 address match.
// - Binding bits 12, 14, 15 gate UDP port 0, EAPoUDP, DNS on match.
// - Binding bits 16-27 gate flexible port filters 0-11 on controller address match.
// - Binding bit 28 gates port range filter, bit 29 gates ICMPv4 filter.
// - Binding bit 30 gates the ARP request filter on controller address match.
// - Binding bit 31 gates the RMCP filter on an IPv4 address match.
module mgmt_host_copy_ip_binding #(
	parameter int NUM_FILTERS = 32
) (
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic [4:0] REG_PHY_ADDR,
	input wire logic [10:0] REG_PAGE,
	input wire logic [5:0] REG_NUM,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [15:0] REG_WDATA,
	output logic [15:0] REG_RDATA,
	output logic REG_RACK,
	input wire logic [31:0] ROUTE_HIT,
	input wire logic [31:0] FILTER_HIT,
	input wire logic MGMT_IP_MATCH,
	input wire logic HOST_IP_MATCH,
	output logic [31:0] HOST_COPY,
	output logic [31:0] FILTER_PASS
);

	// ==========================================================
	// Elaboration checks
	if (NUM_FILTERS != 32) begin : g_bad_width
		$error("Both control registers hold exactly 32 filter bits");
	end

	// ==========================================================
	// Address decode
	wire logic hit_page;
	wire mgmt_filter_pkg::reg_sel_t sel;
	assign hit_page = (REG_PHY_ADDR == `MHB_PHY_ADDR) && (REG_PAGE == `MHB_PAGE);
	assign sel = !hit_page ? mgmt_filter_pkg::SEL_NONE :
		(REG_NUM == `MHB_COPY_LO_NUM) ? mgmt_filter_pkg::SEL_COPY_LO :
		(REG_NUM == `MHB_COPY_HI_NUM) ? mgmt_filter_pkg::SEL_COPY_HI :
		(REG_NUM == `MHB_BIND_LO_NUM) ? mgmt_filter_pkg::SEL_BIND_LO :
		(REG_NUM == `MHB_BIND_HI_NUM) ? mgmt_filter_pkg::SEL_BIND_HI :
		mgmt_filter_pkg::SEL_NONE;

	// ==========================================================
	// Control registers
	mgmt_filter_pkg::ctrl_reg_t copy_ff;
	mgmt_filter_pkg::ctrl_reg_t bind_ff;
	mgmt_filter_pkg::ctrl_reg_t nxt_copy;
	mgmt_filter_pkg::ctrl_reg_t nxt_bind;
	mgmt_filter_pkg::mdio_word_t wlo_copy;
	mgmt_filter_pkg::mdio_word_t whi_copy;
	mgmt_filter_pkg::mdio_word_t wlo_bind;
	mgmt_filter_pkg::mdio_word_t whi_bind;

	// Masking on the way in keeps reserved positions at zero for good
	assign wlo_copy = REG_WDATA & `MHB_COPY_LO_MASK;
	assign whi_copy = REG_WDATA & `MHB_COPY_HI_MASK;
	assign wlo_bind = REG_WDATA & `MHB_BIND_LO_MASK;
	assign whi_bind = REG_WDATA & `MHB_BIND_HI_MASK;

	// Each half is written on its own, the other half keeps its value
	assign nxt_copy[15:0] = (REG_WR && sel == mgmt_filter_pkg::SEL_COPY_LO) ?
		wlo_copy : copy_ff[15:0];
	assign nxt_copy[31:16] = (REG_WR && sel == mgmt_filter_pkg::SEL_COPY_HI) ?
		whi_copy : copy_ff[31:16];
	assign nxt_bind[15:0] = (REG_WR && sel == mgmt_filter_pkg::SEL_BIND_LO) ?
		wlo_bind : bind_ff[15:0];
	assign nxt_bind[31:16] = (REG_WR && sel == mgmt_filter_pkg::SEL_BIND_HI) ?
		whi_bind : bind_ff[31:16];

	// Register update, cleared by reset
	always_ff @(posedge CLOCK) begin
		if (!RESET_N) begin
			copy_ff <= `MHB_COPY_RESET;
			bind_ff <= `MHB_BIND_RESET;
		end else begin
			copy_ff <= nxt_copy;
			bind_ff <= nxt_bind;
		end
	end

	// ==========================================================
	// Read path
	mgmt_filter_pkg::mdio_word_t nxt_rdata;
	// Unmapped numbers answer zero so a stray read never sees stale data
	assign nxt_rdata = (sel == mgmt_filter_pkg::SEL_COPY_LO) ? copy_ff[15:0] :
		(sel == mgmt_filter_pkg::SEL_COPY_HI) ? copy_ff[31:16] :
		(sel == mgmt_filter_pkg::SEL_BIND_LO) ? bind_ff[15:0] :
		(sel == mgmt_filter_pkg::SEL_BIND_HI) ? bind_ff[31:16] :
		16'h0000;

	// Read data held until the next read
	always_ff @(posedge CLOCK) begin
		if (!RESET_N) begin
			REG_RDATA <= 16'h0000;
			REG_RACK <= 1'b0;
		end else begin
			REG_RACK <= REG_RD;
			if (REG_RD) begin
				REG_RDATA <= nxt_rdata;
			end
		end
	end

	// ==========================================================
	// Filter gating
	// Outputs land one cycle after the hit, which costs a cycle of latency but keeps
	// every output on a flip-flop
	filter_gate #(
		.NUM_FILTERS(NUM_FILTERS)
	) u_gate (
		.clk(CLOCK),
		.rst_n(RESET_N),
		.route_hit(ROUTE_HIT),
		.filter_hit(FILTER_HIT),
		.copy_mask(copy_ff),
		.bind_mask(bind_ff),
		.mgmt_ip_match(MGMT_IP_MATCH),
		.host_ip_match(HOST_IP_MATCH),
		.host_copy_ff(HOST_COPY),
		.filter_pass_ff(FILTER_PASS)
	);

	// ==========================================================
	// Assertions
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);

	// Reserved positions never hold a one
	property p_reserved_zero;
		((copy_ff & ~{`MHB_COPY_HI_MASK, `MHB_COPY_LO_MASK}) == 32'h0000_0000) &&
		((bind_ff & ~{`MHB_BIND_HI_MASK, `MHB_BIND_LO_MASK}) == 32'h0000_0000);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("Reserved control bit is set");

	// Reset clears both registers and the outputs
	property p_reset_clear;
		@(posedge CLOCK) disable iff (1'b0)
		!RESET_N |=> (copy_ff == 32'h0000_0000) && (bind_ff == 32'h0000_0000) &&
			(HOST_COPY == 32'h0000_0000) && (FILTER_PASS == 32'h0000_0000);
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("Registers not cleared by reset");

	// Write then read back the same half
	sequence s_wr_copy_lo;
		REG_WR && !REG_RD && sel == mgmt_filter_pkg::SEL_COPY_LO;
	endsequence
	sequence s_rd_copy_lo;
		REG_RD && !REG_WR && sel == mgmt_filter_pkg::SEL_COPY_LO;
	endsequence
	property p_copy_lo_readback;
		s_wr_copy_lo ##1 s_rd_copy_lo |=>
			REG_RACK && REG_RDATA == ($past(REG_WDATA, 2) & `MHB_COPY_LO_MASK);
	endproperty
	a_copy_lo_readback: assert property (p_copy_lo_readback)
		else $error("Copy register low half read back wrong");

	// Unmapped read answers zero
	property p_unmapped_zero;
		RESET_N && REG_RD && sel == mgmt_filter_pkg::SEL_NONE |=>
			REG_RACK && REG_RDATA == 16'h0000;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero)
		else $error("Unmapped read did not return zero");

	// Copy to host for the TCP, UDP, DHCPv6, EAPoUDP and DNS slots
	property p_copy_low_slots;
		RESET_N |=> HOST_COPY[15:0] == $past(ROUTE_HIT[15:0] & copy_ff[15:0]);
	endproperty
	a_copy_low_slots: assert property (p_copy_low_slots)
		else $error("Host copy wrong for low filter slots");

	// Copy to host for the upper slots, reserved slots never copy
	property p_copy_high_slots;
		RESET_N |=> (HOST_COPY[31:16] == $past(ROUTE_HIT[31:16] & copy_ff[31:16])) &&
			(HOST_COPY[31:16] & ~`MHB_COPY_HI_MASK) == 16'h0000;
	endproperty
	a_copy_high_slots: assert property (p_copy_high_slots)
		else $error("Host copy wrong for high filter slots");

	// Bound TCP filter blocks without a controller address match
	property p_tcp_bound_block;
		RESET_N && (FILTER_HIT[10:0] & bind_ff[10:0]) != 11'h000 && !MGMT_IP_MATCH |=>
			(FILTER_PASS[10:0] & $past(bind_ff[10:0])) == 11'h000;
	endproperty
	a_tcp_bound_block: assert property (p_tcp_bound_block)
		else $error("Bound TCP filter passed without address match");

	// Unbound filters pass on the hit alone
	property p_unbound_pass;
		RESET_N |=> (FILTER_PASS & ~$past(bind_ff)) == ($past(FILTER_HIT) & ~$past(bind_ff));
	endproperty
	a_unbound_pass: assert property (p_unbound_pass)
		else $error("Unbound filter did not follow its hit");

	// UDP, EAPoUDP and DNS slots follow the controller address match
	property p_udp_dns_bind;
		RESET_N |=> FILTER_PASS[15:12] == $past(FILTER_HIT[15:12] &
			(~bind_ff[15:12] | {4{MGMT_IP_MATCH}}));
	endproperty
	a_udp_dns_bind: assert property (p_udp_dns_bind)
		else $error("UDP or DNS binding wrong");

	// Flexible port, range, ICMPv4 and ARP slots follow the controller match
	property p_flex_bind;
		RESET_N |=> FILTER_PASS[30:16] == $past(FILTER_HIT[30:16] &
			(~bind_ff[30:16] | {15{MGMT_IP_MATCH}}));
	endproperty
	a_flex_bind: assert property (p_flex_bind)
		else $error("Flexible port binding wrong");

	// Port range and ICMPv4 slots with an address match present
	property p_range_icmp_match;
		RESET_N && FILTER_HIT[28] && FILTER_HIT[29] && MGMT_IP_MATCH |=>
			FILTER_PASS[29:28] == 2'b11;
	endproperty
	a_range_icmp_match: assert property (p_range_icmp_match)
		else $error("Range or ICMPv4 filter blocked despite match");

	// ARP request slot is blocked when bound and unmatched
	property p_arp_bind;
		RESET_N && FILTER_HIT[30] && bind_ff[30] && !MGMT_IP_MATCH |=> !FILTER_PASS[30];
	endproperty
	a_arp_bind: assert property (p_arp_bind)
		else $error("Bound ARP filter passed without match");

	// RMCP slot follows the host address match
	property p_rmcp_bind;
		RESET_N |=> FILTER_PASS[31] == $past(FILTER_HIT[31] & (~bind_ff[31] | HOST_IP_MATCH));
	endproperty
	a_rmcp_bind: assert property (p_rmcp_bind)
		else $error("RMCP binding wrong");

endmodule : mgmt_host_copy_ip_binding

// File: test/mgmt_host_copy_ip_binding_tb.sv
`timescale 1ns/1ps
`include "mgmt_filter_defines.svh"

`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_total++; \
	$display("Error %s expected %h seen %h", nm, ex, got); end end

module mgmt_host_copy_ip_binding_tb;
	logic CLOCK = 1'b0;
	logic RESET_N = 1'b0;
	logic [4:0] REG_PHY_ADDR = `MHB_PHY_ADDR;
	logic [10:0] REG_PAGE = `MHB_PAGE;
	logic [5:0] REG_NUM = 6'h00;
	logic REG_WR = 1'b0;
	logic REG_RD = 1'b0;
	logic [15:0] REG_WDATA = 16'h0000;
	logic [15:0] REG_RDATA;
	logic REG_RACK;
	logic [31:0] ROUTE_HIT;
	logic [31:0] FILTER_HIT;
	logic MGMT_IP_MATCH;
	logic HOST_IP_MATCH;
	logic [31:0] HOST_COPY;
	logic [31:0] FILTER_PASS;
	int err_total = 0;
	int checked = 0;
	logic [5:0] nums [4] = '{`MHB_COPY_LO_NUM, `MHB_COPY_HI_NUM, `MHB_BIND_LO_NUM,
		`MHB_BIND_HI_NUM};
	logic [15:0] masks [4] = '{`MHB_COPY_LO_MASK, `MHB_COPY_HI_MASK, `MHB_BIND_LO_MASK,
		`MHB_BIND_HI_MASK};
	logic [31:0] bind_v;

	// ==========================================================
	// Clock, design and receive-path model
	always #50 CLOCK = ~CLOCK;

	mgmt_host_copy_ip_binding mgmt_host_copy_ip_binding_inst (
		.CLOCK(CLOCK), .RESET_N(RESET_N), .REG_PHY_ADDR(REG_PHY_ADDR), .REG_PAGE(REG_PAGE),
		.REG_NUM(REG_NUM), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
		.REG_RDATA(REG_RDATA), .REG_RACK(REG_RACK), .ROUTE_HIT(ROUTE_HIT),
		.FILTER_HIT(FILTER_HIT), .MGMT_IP_MATCH(MGMT_IP_MATCH),
		.HOST_IP_MATCH(HOST_IP_MATCH), .HOST_COPY(HOST_COPY), .FILTER_PASS(FILTER_PASS)
	);

	pkt_source_model pkt_source_model_inst (
		.clk(CLOCK), .route_hit(ROUTE_HIT), .filter_hit(FILTER_HIT),
		.mgmt_ip_match(MGMT_IP_MATCH), .host_ip_match(HOST_IP_MATCH)
	);

	// ==========================================================
	// Register access tasks; page is a argument so misses can be aimed
	task automatic wr(input logic [10:0] pg, input logic [5:0] num, input logic [15:0] d);
		@(posedge CLOCK);
		REG_PAGE <= pg;
		REG_NUM <= num;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CLOCK);
		REG_WR <= 1'b0;
	endtask : wr

	// Read answers exactly one edge after the strobe, so look right after it
	task automatic rd(input logic [10:0] pg, input logic [5:0] num, input logic [15:0] ex);
		@(posedge CLOCK);
		REG_PAGE <= pg;
		REG_NUM <= num;
		REG_RD <= 1'b1;
		@(posedge CLOCK);
		REG_RD <= 1'b0;
		#1;
		`CHK("read ack", 1'b1, REG_RACK)
		`CHK("read data", ex, REG_RDATA)
	endtask : rd

	// Write and read of one half on adjacent edges; the ack then drops after one cycle
	task automatic wr_rd(input logic [5:0] num, input logic [15:0] d, input logic [15:0] ex);
		@(posedge CLOCK);
		REG_NUM <= num;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CLOCK);
		REG_WR <= 1'b0;
		REG_RD <= 1'b1;
		@(posedge CLOCK);
		REG_RD <= 1'b0;
		#1;
		`CHK("readback ack", 1'b1, REG_RACK)
		`CHK("readback data", ex, REG_RDATA)
		@(posedge CLOCK);
		#1;
		`CHK("ack drop", 1'b0, REG_RACK)
	endtask : wr_rd

	// Launch one packet and compare the outputs one cycle later
	task automatic pkt(input logic [31:0] rt, input logic [31:0] ft, input logic mg,
			input logic hs, input logic [31:0] ex_copy, input logic [31:0] ex_pass);
		pkt_source_model_inst.send(rt, ft, mg, hs);
		#1;
		`CHK("host copy", ex_copy, HOST_COPY)
		`CHK("filter pass", ex_pass, FILTER_PASS)
	endtask : pkt

	// ==========================================================
	// Verdict, shared by the main sequence and the watchdog
	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run

	// Whole sequence needs well under 400 cycles
	initial begin
		#(3000 * 100);
		err_total++;
		complete_run();
	end

	// ==========================================================
	// Main sequence
	initial begin
		repeat (2) @(posedge CLOCK);
		RESET_N <= 1'b1;
		// Every half comes out of reset clear
		foreach (nums[i]) rd(`MHB_PAGE, nums[i], 16'h0000);
		// All ones written: only the writable positions stick
		foreach (nums[i]) wr(`MHB_PAGE, nums[i], 16'hFFFF);
		foreach (nums[i]) rd(`MHB_PAGE, nums[i], masks[i]);
		// Misses: neighbouring number and wrong page leave registers alone
		wr(`MHB_PAGE, 6'h22, 16'hFFFF);
		rd(`MHB_PAGE, 6'h22, 16'h0000);
		wr(11'h320, `MHB_COPY_LO_NUM, 16'h0000);
		// Wrong PHY address: the write is ignored and the read answers zero
		REG_PHY_ADDR <= 5'h02;
		wr(`MHB_PAGE, `MHB_COPY_LO_NUM, 16'h0000);
		rd(`MHB_PAGE, `MHB_COPY_LO_NUM, 16'h0000);
		@(posedge CLOCK);
		REG_PHY_ADDR <= `MHB_PHY_ADDR;
		rd(`MHB_PAGE, `MHB_COPY_LO_NUM, `MHB_COPY_LO_MASK);
		// Copy to host follows only the writable slots, reserved slots never copy
		bind_v = {`MHB_BIND_HI_MASK, `MHB_BIND_LO_MASK};
		pkt(32'hFFFF_FFFF, 32'h0000_0000, 1'b0, 1'b0, 32'h7755_F7FF, 32'h0000_0000);
		// Each matcher combination: slot 31 waits on host match, the rest on controller
		for (int c = 0; c < 4; c++) begin
			pkt(32'h0000_0000, 32'hFFFF_FFFF, c[0], c[1], 32'h0000_0000,
				~bind_v | {c[1], {31{c[0]}}});
		end
		// Single binding bit 3 blocks only its own slot without a match, every other slot passes
		wr(`MHB_PAGE, `MHB_BIND_LO_NUM, 16'h0008);
		wr(`MHB_PAGE, `MHB_BIND_HI_NUM, 16'h0000);
		pkt(32'h0000_1000, 32'h0000_0008, 1'b0, 1'b0, 32'h0000_1000, 32'h0000_0000);
		pkt(32'h0000_0000, 32'hFFFF_FFFF, 1'b0, 1'b0, 32'h0000_0000, 32'hFFFF_FFF7);
		wr(`MHB_PAGE, `MHB_COPY_LO_NUM, 16'h0000);
		pkt(32'hFFFF_FFFF, 32'h0000_0000, 1'b1, 1'b1, 32'h7755_0000, 32'h0000_0000);
		// Back-to-back write and read sees the new value, reserved bit 11 masked
		wr_rd(`MHB_COPY_LO_NUM, 16'h5A5A, 16'h525A);
		// Second reset in mid-run clears everything again
		@(posedge CLOCK);
		RESET_N <= 1'b0;
		repeat (2) @(posedge CLOCK);
		RESET_N <= 1'b1;
		rd(`MHB_PAGE, `MHB_COPY_HI_NUM, 16'h0000);
		rd(`MHB_PAGE, `MHB_BIND_LO_NUM, 16'h0000);
		pkt(32'hFFFF_FFFF, 32'hFFFF_FFFF, 1'b0, 1'b0, 32'h0000_0000, 32'hFFFF_FFFF);
		complete_run();
	end
endmodule : mgmt_host_copy_ip_binding_tb

// File: test/pkt_source_model.sv
`timescale 1ns/1ps

// ==========================================================
// Receive-path stand-in: filter engines and address matchers
module pkt_source_model (
	input wire logic clk,
	output logic [31:0] route_hit,
	output logic [31:0] filter_hit,
	output logic mgmt_ip_match,
	output logic host_ip_match
);
	// Idle between packets: no filter reports a hit
	initial begin
		route_hit = 32'h0000_0000;
		filter_hit = 32'h0000_0000;
		mgmt_ip_match = 1'b0;
		host_ip_match = 1'b0;
	end

	// One packet's verdicts, launched just after a rising edge
	task automatic send(input logic [31:0] rt, input logic [31:0] ft, input logic mg,
			input logic hs);
		@(posedge clk);
		route_hit <= rt;
		filter_hit <= ft;
		mgmt_ip_match <= mg;
		host_ip_match <= hs;
		// Verdicts stand for one cycle only, then the path goes idle again
		@(posedge clk);
		route_hit <= 32'h0000_0000;
		filter_hit <= 32'h0000_0000;
		mgmt_ip_match <= 1'b0;
		host_ip_match <= 1'b0;
	endtask : send
endmodule : pkt_source_model
